/* File: common/tpwm_defines.svh */
`ifndef TPWM_DEFINES_SVH
`define TPWM_DEFINES_SVH

// counter, period limit and compare reset values
`define TPWM_COUNT_RST     16'h0000
`define TPWM_LIMIT_RST     16'hffff
`define TPWM_CMP_RST       16'h0000
// prescaler: bus clock divided by up to 64, code 7 selects the clock pin
`define TPWM_PRESC_W       6
`define TPWM_PRESC_RST     6'h00
`define TPWM_PRESC_EXT     3'h7
// compare polarity pair {high,low}
`define TPWM_POL_OFF       2'h0
`define TPWM_POL_TOGGLE    2'h1
`define TPWM_POL_CLEAR     2'h2
`define TPWM_POL_SET       2'h3
// channel indices of the two linkable pairs
`define TPWM_PAIR01_LEAD   0
`define TPWM_PAIR23_LEAD   2

`endif

/* File: common/tpwm_pkg.sv */
package tpwm_pkg;

	// per channel control bits
	typedef struct packed {
		logic mode_select_high;
		logic mode_select_low;
		logic compare_polarity_high_bit;
		logic compare_polarity_low_bit;
		logic toggle_on_wrap;
		logic full_duty_select;
		logic channel_irq_enable;
	} tpwm_chan_cfg_t;

	// pin drive of one channel
	typedef struct packed {
		logic level;
		logic oe_n;
	} tpwm_pin_t;

endpackage : tpwm_pkg

/* File: hw/tpwm_channels.sv */
// Summary of operation
// R01 - output toggles when the counter reaches the period limit
// R02 - pulse lasts from wrap until the counter equals the compare value
// R03 - code 000 with limit 255 gives a 256 bus clock period
// R04 - pair01_link joins channels 0 and 1, channel 0 values first
// R05 - writing the other set hands over at next wrap, last written governs
// R06 - linked: channel 0 control governs, channel 1 pin freed
// R07 - pair23_link joins channels 2 and 3 likewise, channel 3 pin freed
// R08 - link bit wins over the low mode bit on channels 0 and 2
// R09 - mode 0:1 unbuffered, 1:0 buffered compare and PWM on channels 0 and 2, unbuffered on channels 1 and 3
// R10 - polarity 1:0 clears on compare, 1:1 sets on compare
// R11 - toggle_on_wrap clear gives no wrap toggle, so 0% duty
// R12 - full_duty_select with toggle_on_wrap gives 100% duty
// R13 - wrap flag on reaching limit, interrupt only when enabled
// R14 - channel flag on compare, interrupt only when enabled
// R15 - counts in wait, writes ignored, enabled request wakes
// R16 - equality compare can be missed for a period after a late write
// R17 - software stops, resets, loads, configures, then releases the counter
// R18 - software must not use toggle on compare for PWM
// R19 - software writes widths only to the inactive set of a pair
// R20 - software shortens from compare irq, lengthens from wrap irq
// R21 - after the limit the counter restarts from zero next tick
// R22 - prescale codes 0..6 divide by 1..64, code 7 uses the pin
// R23 - counter reset clears counter and prescaler only
`timescale 1ns/10ps
`include "tpwm_defines.svh"

module tpwm_channels (
	input  wire logic                           SYS_CLK,
	input  wire logic                           RST_N,
	input  wire logic                           EXTERNAL_TIMER_CLOCK_PIN,
	input  wire logic                           COUNTER_HALT,
	input  wire logic                           COUNTER_RESET,
	input  wire logic [2:0]                     PRESCALE_CODE,
	input  wire logic [15:0]                    PERIOD_LIMIT,
	input  wire logic                           WRAP_IRQ_ENABLE,
	input  wire logic                           WRAP_FLAG_CLR,
	input  wire tpwm_pkg::tpwm_chan_cfg_t [3:0] CHAN_CFG,
	input  wire logic [3:0]                     CMP_WR,
	input  wire logic [15:0]                    CMP_DATA,
	input  wire logic [3:0]                     CHAN_FLAG_CLR,
	input  wire logic                           WAIT_MODE,
	output logic [3:0]                          CHAN_PIN_OUT,
	output logic [3:0]                          CHAN_PIN_OE_N,
	output logic [15:0]                         COUNT,
	output logic                                WRAP_FLAG,
	output logic [3:0]                          CHAN_FLAG,
	output logic [1:0]                          ACTIVE_SET,
	output logic                                IRQ,
	output logic                                WAKE_REQ
);

	logic [2:0]               clk_pin_sync_reg;
	logic                     clk_pin_level_reg;
	logic                     ext_edge;
	logic [`TPWM_PRESC_W-1:0] presc_reg;
	logic [`TPWM_PRESC_W-1:0] presc_mask;
	logic                     tick;
	logic                     wrap_evt;
	logic [15:0]              count_reg;
	logic [15:0]              cmp_reg [4];
	logic [15:0]              cmp_eff [4];
	logic [1:0]               pend_reg;
	logic [1:0]               sel_reg;
	logic [1:0]               link;
	logic [3:0]               live;
	logic [3:0]               match;
	logic [3:0]               wr_ok;
	tpwm_pkg::tpwm_pin_t      pin_next [4];
	tpwm_pkg::tpwm_pin_t      pin_reg [4];
	logic [3:0]               chan_flag_reg;
	logic                     wrap_flag_reg;
	logic                     irq_next;
	logic                     irq_reg;
	logic                     wake_reg;
	logic [1:0]               pol [4];

	// processor side writes are shut out while in wait
	assign wr_ok = WAIT_MODE ? 4'h0 : CMP_WR; // R15

	// three stage sync; a level counts once stages two and three agree
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			clk_pin_sync_reg  <= 3'h0;
			clk_pin_level_reg <= 1'h0;
		end else begin
			clk_pin_sync_reg <= {clk_pin_sync_reg[1:0],
				EXTERNAL_TIMER_CLOCK_PIN};
			if (clk_pin_sync_reg[1] == clk_pin_sync_reg[2])
				clk_pin_level_reg <= clk_pin_sync_reg[2];
		end
	end

	assign ext_edge = (clk_pin_sync_reg[1] == clk_pin_sync_reg[2]) &&
		clk_pin_sync_reg[2] && !clk_pin_level_reg;

	// power of two divider: tick when the low code bits are all ones
	assign presc_mask = `TPWM_PRESC_W'((7'h01 << PRESCALE_CODE) - 7'h01);
	assign tick = !COUNTER_HALT && !COUNTER_RESET &&
		((PRESCALE_CODE == `TPWM_PRESC_EXT) ? ext_edge :
		((presc_reg & presc_mask) == presc_mask)); // R22 R03
	assign wrap_evt = tick && (count_reg == PERIOD_LIMIT); // R13

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N)
			presc_reg <= `TPWM_PRESC_RST;
		else if (COUNTER_RESET)
			presc_reg <= `TPWM_PRESC_RST; // R23
		else if (!COUNTER_HALT)
			presc_reg <= presc_reg + `TPWM_PRESC_W'(1);
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N)
			count_reg <= `TPWM_COUNT_RST;
		else if (COUNTER_RESET)
			count_reg <= `TPWM_COUNT_RST; // R23
		else if (wrap_evt)
			count_reg <= `TPWM_COUNT_RST; // R21 R01
		else if (tick)
			count_reg <= count_reg + 16'h0001;
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			for (int i = 0; i < 4; i++)
				cmp_reg[i] <= `TPWM_CMP_RST;
		end else begin
			for (int i = 0; i < 4; i++)
				if (wr_ok[i])
					cmp_reg[i] <= CMP_DATA;
		end
	end

	// pair handover: last written set takes over at the next wrap
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			pend_reg <= 2'h0;
			sel_reg  <= 2'h0;
		end else begin
			for (int p = 0; p < 2; p++) begin
				if (!link[p]) begin
					pend_reg[p] <= 1'h0; // R04 R07
					sel_reg[p]  <= 1'h0;
				end else begin
					if (wr_ok[2*p+1] && !wr_ok[2*p])
						pend_reg[p] <= 1'h1; // R05
					else if (wr_ok[2*p])
						pend_reg[p] <= 1'h0; // R05
					if (wrap_evt)
						sel_reg[p] <= pend_reg[p]; // R05
				end
			end
		end
	end

	always_comb begin
		link[0] = CHAN_CFG[`TPWM_PAIR01_LEAD].mode_select_high; // R04
		link[1] = CHAN_CFG[`TPWM_PAIR23_LEAD].mode_select_high; // R07
		for (int i = 0; i < 4; i++) begin
			pol[i] = {CHAN_CFG[i].compare_polarity_high_bit,
				CHAN_CFG[i].compare_polarity_low_bit};
			cmp_eff[i] = cmp_reg[i];
			// either mode bit enables; the link bit wins on leads
			live[i] = CHAN_CFG[i].mode_select_high |
				CHAN_CFG[i].mode_select_low; // R09 R08
		end
		for (int p = 0; p < 2; p++)
			if (link[p]) begin
				cmp_eff[2*p] = sel_reg[p] ? cmp_reg[2*p+1] : cmp_reg[2*p];
				live[2*p+1] = 1'h0; // R06 R07
			end
		for (int i = 0; i < 4; i++)
			// equality only: a value already passed waits a period
			match[i] = tick && live[i] && (count_reg == cmp_eff[i]); // R02 R16
	end

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pin_next[i].level = pin_reg[i].level;
			pin_next[i].oe_n  = !(live[i] && (pol[i] != `TPWM_POL_OFF));
			if (live[i] && wrap_evt && CHAN_CFG[i].toggle_on_wrap) begin
				if (CHAN_CFG[i].full_duty_select)
					pin_next[i].level = !pol[i][0]; // R12
				else
					pin_next[i].level = !pin_reg[i].level; // R01
			end
			// without wrap toggles compares push to the idle level: 0%
			if (match[i] && !(CHAN_CFG[i].full_duty_select &&
				CHAN_CFG[i].toggle_on_wrap)) begin // R11
				case (pol[i])
					`TPWM_POL_CLEAR:  pin_next[i].level = 1'h0; // R10
					`TPWM_POL_SET:    pin_next[i].level = 1'h1; // R10
					`TPWM_POL_TOGGLE: pin_next[i].level = !pin_reg[i].level;
					default:          pin_next[i].level = pin_reg[i].level;
				endcase
			end
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			for (int i = 0; i < 4; i++)
				pin_reg[i] <= '{level: 1'h0, oe_n: 1'h1};
		end else begin
			for (int i = 0; i < 4; i++)
				pin_reg[i] <= pin_next[i];
		end
	end

	// set wins over a clear in the same cycle
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			wrap_flag_reg <= 1'h0;
			chan_flag_reg <= 4'h0;
		end else begin
			wrap_flag_reg <= (wrap_flag_reg &&
				!(WRAP_FLAG_CLR && !WAIT_MODE)) || wrap_evt; // R13
			for (int i = 0; i < 4; i++)
				chan_flag_reg[i] <= (chan_flag_reg[i] &&
					!(CHAN_FLAG_CLR[i] && !WAIT_MODE)) || match[i]; // R14
		end
	end

	always_comb begin
		irq_next = wrap_flag_reg && WRAP_IRQ_ENABLE; // R13
		for (int i = 0; i < 4; i++)
			irq_next = irq_next || (chan_flag_reg[i] &&
				CHAN_CFG[i].channel_irq_enable); // R14
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			irq_reg  <= 1'h0;
			wake_reg <= 1'h0;
		end else begin
			irq_reg  <= irq_next;
			wake_reg <= irq_next && WAIT_MODE; // R15
		end
	end

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			CHAN_PIN_OUT[i]  = pin_reg[i].level;
			CHAN_PIN_OE_N[i] = pin_reg[i].oe_n;
		end
	end

	assign COUNT      = count_reg;
	assign WRAP_FLAG  = wrap_flag_reg;
	assign CHAN_FLAG  = chan_flag_reg;
	assign ACTIVE_SET = sel_reg;
	assign IRQ        = irq_reg;
	assign WAKE_REQ   = wake_reg;

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);

	sequence s_write_other;
		link[0] && wr_ok[1] && !wr_ok[0] && !wrap_evt;
	endsequence

	sequence s_wrap_kept;
		wrap_evt && link[0] && !wr_ok[0];
	endsequence

	a_counter_restart: assert property ( // R21
		wrap_evt && !COUNTER_RESET |=> COUNT == 16'h0000)
		else $error("no restart at limit");
	a_direct_tick: assert property ( // R03
		PRESCALE_CODE == 3'h0 && !COUNTER_HALT && !COUNTER_RESET
		|-> tick)
		else $error("divide by one missed");
	a_wrap_flag_set: assert property (wrap_evt |=> WRAP_FLAG) // R13
		else $error("wrap flag not set");
	a_wrap_irq: assert property ( // R13
		WRAP_FLAG && WRAP_IRQ_ENABLE |=> IRQ)
		else $error("wrap request missing");
	a_chan_irq: assert property ( // R14
		CHAN_FLAG[0] && CHAN_CFG[0].channel_irq_enable |=> IRQ)
		else $error("channel request missing");
	a_wrap_toggle: assert property ( // R01
		wrap_evt && live[0] && CHAN_CFG[0].toggle_on_wrap &&
		!CHAN_CFG[0].full_duty_select && !match[0]
		|=> CHAN_PIN_OUT[0] != $past(CHAN_PIN_OUT[0]))
		else $error("no toggle at wrap");
	a_zero_duty: assert property ( // R11
		wrap_evt && !CHAN_CFG[0].toggle_on_wrap && !match[0]
		|=> $stable(CHAN_PIN_OUT[0]))
		else $error("toggle without enable");
	a_full_duty: assert property ( // R12
		live[0] && pol[0] == 2'h2 && CHAN_CFG[0].toggle_on_wrap &&
		CHAN_CFG[0].full_duty_select && wrap_evt
		|=> ##[0:1] CHAN_PIN_OUT[0])
		else $error("full duty lost");
	a_clear_compare: assert property ( // R10
		match[0] && pol[0] == 2'h2 && !CHAN_CFG[0].full_duty_select
		|=> !CHAN_PIN_OUT[0])
		else $error("clear on compare failed");
	a_pair_freed: assert property (link[0] |=> CHAN_PIN_OE_N[1]) // R06
		else $error("linked pin still driven");
	a_pair_handover: assert property ( // R05
		s_write_other ##1 s_wrap_kept |=> ACTIVE_SET[0])
		else $error("handover missed");
	a_reset_count: assert property ( // R23
		COUNTER_RESET |=> COUNT == 16'h0000)
		else $error("counter reset ignored");

endmodule : tpwm_channels

/* File: tb/tpwm_load.sv */
`timescale 1ns/10ps
module tpwm_load (
	input  wire logic [3:0] out,
	input  wire logic [3:0] oe_n,
	output logic [3:0]      lvl
);
	// the load resistor pulls a released pin down
	assign lvl = ~oe_n & out;
endmodule : tpwm_load

/* File: tb/testbench.sv */
`timescale 1ns/10ps
module testbench;
	logic                           clk = 1'b0;
	logic                           rst_n = 1'b0;
	logic                           ext = 1'b0;
	logic                           halt = 1'b1;
	logic                           creset = 1'b0;
	logic [2:0]                     psc = 3'h0;
	logic [15:0]                    limit = 16'hffff;
	logic                           wie = 1'b0;
	logic                           wclr = 1'b0;
	tpwm_pkg::tpwm_chan_cfg_t [3:0] cfg = '0;
	logic [3:0]                     cwr = 4'h0;
	logic [15:0]                    cdata = 16'h0000;
	logic [3:0]                     fclr = 4'h0;
	logic                           wait_m = 1'b0;
	logic [3:0]                     pin, oe_n, lvl, cflag;
	logic [15:0]                    count;
	logic [1:0]                     aset;
	logic                           wflag, irq, wake;
	int                             n_fail = 0;
	int                             checks = 0;
	int                             hi;

	always #50 clk = ~clk;
	always #400 ext = ~ext;

	tpwm_channels uut (.SYS_CLK(clk), .RST_N(rst_n),
		.EXTERNAL_TIMER_CLOCK_PIN(ext), .COUNTER_HALT(halt),
		.COUNTER_RESET(creset), .PRESCALE_CODE(psc), .PERIOD_LIMIT(limit),
		.WRAP_IRQ_ENABLE(wie), .WRAP_FLAG_CLR(wclr), .CHAN_CFG(cfg),
		.CMP_WR(cwr), .CMP_DATA(cdata), .CHAN_FLAG_CLR(fclr),
		.WAIT_MODE(wait_m), .CHAN_PIN_OUT(pin), .CHAN_PIN_OE_N(oe_n),
		.COUNT(count), .WRAP_FLAG(wflag), .CHAN_FLAG(cflag),
		.ACTIVE_SET(aset), .IRQ(irq), .WAKE_REQ(wake));
	tpwm_load load (.out(pin), .oe_n(oe_n), .lvl(lvl));

	task automatic chk(input string what, input logic [15:0] seen,
			input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic complete_run;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run

	// stop, clear, load period and width, configure, release
	task automatic setup(input logic [15:0] lim, input logic [15:0] w,
			input logic [6:0] c);
		@(negedge clk) halt = 1'b1;
		creset = 1'b1;
		@(negedge clk) creset = 1'b0;
		limit = lim;
		cdata = w;
		cwr = 4'h1;
		@(negedge clk) cwr = 4'h0;
		cfg[0] = c;
		@(negedge clk) halt = 1'b0;
	endtask : setup

	// one full period starting at the wrap, ends with count at the limit
	task automatic measure(input logic [15:0] lim);
		int i;
		hi = 0;
		i = 0;
		while (count !== lim && i < 1000) begin
			@(negedge clk);
			i++;
		end
		// a counter that never reaches the limit shows up here
		chk("period_sync", count, lim);
		for (i = 0; i <= lim; i++) begin
			@(negedge clk);
			hi += lvl[0];
		end
	endtask : measure

	task automatic t_pwm;
		setup(16'h00ff, 16'h0080, 7'h34);
		measure(16'h00ff);
		measure(16'h00ff);
		chk("high_true", hi, 16'd129);
		chk("period", count, 16'h00ff);
		cfg[0] = 7'h3c;
		measure(16'h00ff);
		measure(16'h00ff);
		chk("low_true", hi, 16'd127);
		chk("restart", count, 16'h00ff);
		$display("done pwm");
	endtask : t_pwm

	task automatic t_duty;
		setup(16'h000f, 16'h0008, 7'h30);
		measure(16'h000f);
		measure(16'h000f);
		chk("duty0", hi, 16'd0);
		cfg[0] = 7'h36;
		measure(16'h000f);
		measure(16'h000f);
		chk("duty100", hi, 16'd16);
		$display("done duty");
	endtask : t_duty

	task automatic t_flags;
		setup(16'h000f, 16'h0008, 7'h34);
		measure(16'h000f);
		chk("wrap_flag", wflag, 16'h1);
		chk("chan_flag", cflag[0], 16'h1);
		chk("irq_off", irq, 16'h0);
		wie = 1'b1;
		repeat (2) @(negedge clk);
		chk("irq_wrap", irq, 16'h1);
		wclr = 1'b1;
		fclr = 4'hf;
		wie = 1'b0;
		@(negedge clk) wclr = 1'b0;
		fclr = 4'h0;
		@(negedge clk) chk("wrap_clr", wflag, 16'h0);
		chk("chan_clr", cflag[0], 16'h0);
		cfg[0] = 7'h35;
		repeat (7) @(negedge clk);
		chk("irq_chan", irq, 16'h1);
		chk("wrap_quiet", wflag, 16'h0);
		cdata = 16'h0004;
		cwr = 4'h1;
		@(negedge clk) cwr = 4'h0;
		measure(16'h000f);
		chk("shorter", hi, 16'd5);
		repeat (2) @(negedge clk);
		cdata = 16'h000c;
		cwr = 4'h1;
		@(negedge clk) cwr = 4'h0;
		measure(16'h000f);
		chk("longer", hi, 16'd13);
		$display("done flags");
	endtask : t_flags

	task automatic t_buffer;
		cfg[1] = 7'h34;
		cfg[3] = 7'h34;
		setup(16'h000f, 16'h0004, 7'h74);
		measure(16'h000f);
		measure(16'h000f);
		chk("set0_width", hi, 16'd5);
		chk("set0_active", aset[0], 16'h0);
		chk("ch1_freed", oe_n[1], 16'h1);
		// write one count before the wrap so the handover comes at that wrap
		repeat (15) @(negedge clk);
		cdata = 16'h000a;
		cwr = 4'h2;
		@(negedge clk) cwr = 4'h0;
		chk("no_early", aset[0], 16'h0);
		measure(16'h000f);
		chk("set1_width", hi, 16'd11);
		chk("set1_active", aset[0], 16'h1);
		measure(16'h000f);
		chk("set1_holds", hi, 16'd11);
		cfg[2] = 7'h54;
		@(negedge clk) chk("ch2_drives", oe_n[2], 16'h0);
		chk("ch3_freed", oe_n[3], 16'h1);
		chk("set2_first", aset[1], 16'h0);
		cfg = '0;
		$display("done buffer");
	endtask : t_buffer

	task automatic t_wait;
		setup(16'h000f, 16'h0004, 7'h34);
		wait_m = 1'b1;
		wie = 1'b1;
		cdata = 16'h0002;
		cwr = 4'h1;
		wclr = 1'b1;
		@(negedge clk) cwr = 4'h0;
		wclr = 1'b0;
		chk("clr_blocked", wflag, 16'h1);
		measure(16'h000f);
		measure(16'h000f);
		chk("wait_width", hi, 16'd5);
		chk("wait_count", count, 16'h000f);
		chk("wait_flag", wflag, 16'h1);
		chk("wake", wake, 16'h1);
		wait_m = 1'b0;
		wie = 1'b0;
		$display("done wait");
	endtask : t_wait

	task automatic t_presc;
		logic [15:0] held;
		for (int k = 0; k < 7; k++) begin
			@(negedge clk) creset = 1'b1;
			psc = k[2:0];
			limit = 16'hffff;
			halt = 1'b0;
			@(negedge clk) creset = 1'b0;
			repeat (64) @(negedge clk);
			chk("divide", count, 16'd64 >> k);
		end
		held = count;
		halt = 1'b1;
		repeat (5) @(negedge clk);
		chk("halt", count, held);
		psc = 3'h7;
		creset = 1'b1;
		@(negedge clk) creset = 1'b0;
		halt = 1'b0;
		repeat (40) @(negedge clk);
		chk("ext_clock", {15'h0, count >= 3 && count <= 6}, 16'h1);
		$display("done prescaler");
	endtask : t_presc

	initial begin
		repeat (6) @(negedge clk);
		chk("rst_oe", oe_n, 16'h000f);
		chk("rst_count", count, 16'h0000);
		rst_n = 1'b1;
		t_pwm();
		t_duty();
		t_flags();
		t_buffer();
		t_wait();
		t_presc();
		complete_run();
	end

	initial begin
		// about five times the length of a clean run
		#1000000;
		n_fail++;
		complete_run();
	end
endmodule : testbench
